// ===== pkg/arfw_pkg.sv
// Purpose: shared constants for the result format and window block
// Assumes: 8-bit registers, each on one aligned 32-bit AHB word
// Notes: register offsets are word indices; byte address = 4 * index
package arfw_pkg;
   // word indices of the registers
   localparam logic [7:0] IDX_PAIR_CFG = 8'hBA;
   localparam logic [7:0] IDX_CHAN_SEL = 8'hBB;
   localparam logic [7:0] IDX_RES_LO = 8'hBE;
   localparam logic [7:0] IDX_RES_HI = 8'hBF;
   localparam logic [7:0] IDX_GT_LO = 8'hC4;
   localparam logic [7:0] IDX_GT_HI = 8'hC5;
   localparam logic [7:0] IDX_LT_LO = 8'hC6;
   localparam logic [7:0] IDX_LT_HI = 8'hC7;
   localparam logic [7:0] IDX_STATUS = 8'hD0;
   localparam logic [7:0] IDX_MASK = 8'hD1;
   localparam logic [7:0] IDX_CTRL = 8'hE8;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_GT_HI = 8'hFF;
   localparam logic [7:0] RST_GT_LO = 8'hFF;
   // field positions
   localparam int CTRL_LJ_BIT = 0;
   localparam int CTRL_WIN_BIT = 1;
   localparam int ST_WIN_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int NUM_EVENTS = 2;
   localparam int PAIR_CFG_W = 4;
   localparam int CHAN_SEL_W = 4;
   localparam int CHAN_TEMP_BIT = 3;
   localparam int ADC_W = 10;
   localparam int PAD_W = 6;
   // bus side
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
   localparam logic [23:0] RD_PAD = 24'h000000;
   localparam logic [31:0] RD_ZERO = 32'h00000000;
   localparam logic HRESP_OKAY = 1'b0;
   // bus data phase states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WRITE = 4'h2,
      ST_RWAIT = 4'h4,
      ST_RDATA = 4'h8
   } arfw_bus_state_t;
endpackage : arfw_pkg

// ===== verilog/arfw_top.sv
// Purpose: formats the 10-bit converter result and checks it against
//    a programmable window, with an AHB-Lite register slave
// Assumes: conv_done and conv_data come from converter logic on hclk
// Notes: reads take one wait state, writes none
`timescale 1ns/1ps
`default_nettype none

// How it works
// - right justified: top two bits in high bits 1..0, low eight in low byte
// - right justified high bits 7..2 copy bit 1 if differential, else zero
// - left justified: upper eight result bits go to the high byte
// - left justified: low byte bits 7..6 hold low two bits, rest zero
// - single-ended results are plain unsigned binary codes
// - differential results are two's complement codes
// - every result is compared against both limit words
// - less-than above greater-than: match only strictly inside both limits
// - less-than below greater-than: match when strictly outside either limit
// - differential comparison treats result and limits as signed
// - limit words are high byte over low byte, same justified layout
// - match flag works polled or as interrupt; non-matches leave it alone
// - match flag stays set until software clears it
// - justify bit zero gives right layout, one gives left layout
// - differential channels always produce two's complement results
module arfw_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // converter result
   input wire logic conv_done,
   input wire logic [arfw_pkg::ADC_W-1:0] conv_data,
   // interrupt
   output logic irq
);
   arfw_pkg::arfw_bus_state_t state_r, state_nxt;
   logic [7:0] idx_r;
   logic [7:0] rd_val;
   logic [31:0] hrdata_r;
   logic accept;
   logic wr_en;
   logic [7:0] wdat;
   logic [arfw_pkg::PAIR_CFG_W-1:0] pair_cfg_r;
   logic [arfw_pkg::CHAN_SEL_W-1:0] chan_sel_r;
   logic result_left_justify_r;
   logic [7:0] res_lo_r, res_hi_r;
   logic [7:0] gt_lo_r, gt_hi_r, lt_lo_r, lt_hi_r;
   logic [arfw_pkg::NUM_EVENTS-1:0] status_r, mask_r, events;
   logic diff;
   logic [15:0] fmt_word, lt_word, gt_word;
   logic signed [16:0] res_s, lt_s, gt_s;
   logic match;
   logic window_match_flag;

   // ---------------- bus slave ----------------
   assign accept = hsel && hready && htrans[1] &&
                   (htrans == arfw_pkg::HTRANS_NONSEQ_BIT);
   assign wr_en = (state_r == arfw_pkg::ST_WRITE);
   assign wdat = hwdata[7:0];
   assign hreadyout = (state_r != arfw_pkg::ST_RWAIT);
   assign hresp = arfw_pkg::HRESP_OKAY;
   assign hrdata = hrdata_r;

   always_comb begin
      state_nxt = arfw_pkg::ST_IDLE;
      case (state_r)
         arfw_pkg::ST_RWAIT: begin
            state_nxt = arfw_pkg::ST_RDATA;
         end
         default: begin
            if (accept) begin
               state_nxt = hwrite ? arfw_pkg::ST_WRITE
                                  : arfw_pkg::ST_RWAIT;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= arfw_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_r <= arfw_pkg::RST_ZERO;
      end else if (accept) begin
         idx_r <= haddr[arfw_pkg::IDX_MSB:arfw_pkg::IDX_LSB];
      end
   end

   // read value sampled in the wait state, so a write just before is seen
   always_comb begin
      if (idx_r == arfw_pkg::IDX_PAIR_CFG) begin
         rd_val = {4'h0, pair_cfg_r};
      end else if (idx_r == arfw_pkg::IDX_CHAN_SEL) begin
         rd_val = {4'h0, chan_sel_r};
      end else if (idx_r == arfw_pkg::IDX_RES_LO) begin
         rd_val = res_lo_r;
      end else if (idx_r == arfw_pkg::IDX_RES_HI) begin
         rd_val = res_hi_r;
      end else if (idx_r == arfw_pkg::IDX_GT_LO) begin
         rd_val = gt_lo_r;
      end else if (idx_r == arfw_pkg::IDX_GT_HI) begin
         rd_val = gt_hi_r;
      end else if (idx_r == arfw_pkg::IDX_LT_LO) begin
         rd_val = lt_lo_r;
      end else if (idx_r == arfw_pkg::IDX_LT_HI) begin
         rd_val = lt_hi_r;
      end else if (idx_r == arfw_pkg::IDX_STATUS) begin
         rd_val = {6'h00, status_r};
      end else if (idx_r == arfw_pkg::IDX_MASK) begin
         rd_val = {6'h00, mask_r};
      end else if (idx_r == arfw_pkg::IDX_CTRL) begin
         rd_val = {6'h00, window_match_flag, result_left_justify_r};
      end else begin
         rd_val = arfw_pkg::RST_ZERO;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= arfw_pkg::RD_ZERO;
      end else if (state_r == arfw_pkg::ST_RWAIT) begin
         hrdata_r <= {arfw_pkg::RD_PAD, rd_val};
      end
   end

   // ---------------- configuration ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_cfg_r <= arfw_pkg::RST_ZERO[arfw_pkg::PAIR_CFG_W-1:0];
         chan_sel_r <= arfw_pkg::RST_ZERO[arfw_pkg::CHAN_SEL_W-1:0];
         result_left_justify_r <= 1'b0;
         mask_r <= arfw_pkg::RST_ZERO[arfw_pkg::NUM_EVENTS-1:0];
      end else if (wr_en) begin
         if (idx_r == arfw_pkg::IDX_PAIR_CFG) begin
            pair_cfg_r <= wdat[arfw_pkg::PAIR_CFG_W-1:0];
         end else if (idx_r == arfw_pkg::IDX_CHAN_SEL) begin
            chan_sel_r <= wdat[arfw_pkg::CHAN_SEL_W-1:0];
         end else if (idx_r == arfw_pkg::IDX_CTRL) begin
            result_left_justify_r <= wdat[arfw_pkg::CTRL_LJ_BIT];
         end else if (idx_r == arfw_pkg::IDX_MASK) begin
            mask_r <= wdat[arfw_pkg::NUM_EVENTS-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gt_lo_r <= arfw_pkg::RST_GT_LO;
         gt_hi_r <= arfw_pkg::RST_GT_HI;
         lt_lo_r <= arfw_pkg::RST_ZERO;
         lt_hi_r <= arfw_pkg::RST_ZERO;
      end else if (wr_en) begin
         if (idx_r == arfw_pkg::IDX_GT_LO) begin
            gt_lo_r <= wdat;
         end else if (idx_r == arfw_pkg::IDX_GT_HI) begin
            gt_hi_r <= wdat;
         end else if (idx_r == arfw_pkg::IDX_LT_LO) begin
            lt_lo_r <= wdat;
         end else if (idx_r == arfw_pkg::IDX_LT_HI) begin
            lt_hi_r <= wdat;
         end
      end
   end

   // ---------------- formatting ----------------
   // temperature sensor channel is always single-ended
   assign diff = !chan_sel_r[arfw_pkg::CHAN_TEMP_BIT] &&
                 pair_cfg_r[chan_sel_r[2:1]];

   always_comb begin
      if (result_left_justify_r) begin
         fmt_word = {conv_data, {arfw_pkg::PAD_W{1'b0}}};
      end else begin
         fmt_word = {{arfw_pkg::PAD_W{diff & conv_data[9]}},
                     conv_data};
      end
   end

   // a new result overrides a software write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_lo_r <= arfw_pkg::RST_ZERO;
         res_hi_r <= arfw_pkg::RST_ZERO;
      end else if (conv_done) begin
         res_hi_r <= fmt_word[15:8];
         res_lo_r <= fmt_word[7:0];
      end else if (wr_en && idx_r == arfw_pkg::IDX_RES_LO) begin
         res_lo_r <= wdat;
      end else if (wr_en && idx_r == arfw_pkg::IDX_RES_HI) begin
         res_hi_r <= wdat;
      end
   end

   // ---------------- window compare ----------------
   assign lt_word = {lt_hi_r, lt_lo_r};
   assign gt_word = {gt_hi_r, gt_lo_r};
   // one extra bit makes a single signed comparator serve both modes
   assign res_s = $signed({diff & fmt_word[15], fmt_word});
   assign lt_s = $signed({diff & lt_word[15], lt_word});
   assign gt_s = $signed({diff & gt_word[15], gt_word});

   always_comb begin
      if (lt_s > gt_s) begin
         match = (res_s < lt_s) && (res_s > gt_s);
      end else begin
         match = (res_s < lt_s) || (res_s > gt_s);
      end
   end

   assign events[arfw_pkg::ST_WIN_BIT] = conv_done && match;
   assign events[arfw_pkg::ST_DONE_BIT] = conv_done;

   // ---------------- sticky status, write one to clear ----------------
   genvar gi;
   generate
      for (gi = 0; gi < arfw_pkg::NUM_EVENTS; gi++) begin : g_stat
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               status_r[gi] <= 1'b0;
            end else if (events[gi]) begin
               status_r[gi] <= 1'b1;
            end else if (wr_en &&
                         ((idx_r == arfw_pkg::IDX_STATUS && wdat[gi]) ||
                          (idx_r == arfw_pkg::IDX_CTRL &&
                           gi == arfw_pkg::ST_WIN_BIT &&
                           wdat[arfw_pkg::CTRL_WIN_BIT]))) begin
               // the control word clears on its flag bit, never on justify
               status_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign window_match_flag = status_r[arfw_pkg::ST_WIN_BIT];
   assign irq = |(status_r & mask_r);

   // ---------------- checks ----------------
   logic win_clr;
   assign win_clr = wr_en &&
                    ((idx_r == arfw_pkg::IDX_STATUS &&
                      wdat[arfw_pkg::ST_WIN_BIT]) ||
                     (idx_r == arfw_pkg::IDX_CTRL &&
                      wdat[arfw_pkg::CTRL_WIN_BIT]));

   chk_right_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && !result_left_justify_r |=>
         res_lo_r == $past(conv_data[7:0]) &&
         res_hi_r[1:0] == $past(conv_data[9:8]))
      else $error("right justified low bits misplaced");

   chk_right_sign: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && !result_left_justify_r |=>
         res_hi_r[7:2] == {6{$past(diff) & res_hi_r[1]}})
      else $error("right justified upper bits wrong");

   chk_left_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && result_left_justify_r |=>
         res_hi_r == $past(conv_data[9:2]))
      else $error("left justified high byte wrong");

   chk_left_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && result_left_justify_r |=>
         res_lo_r[7:6] == $past(conv_data[1:0]) && res_lo_r[5:0] == 6'h00)
      else $error("left justified low byte wrong");

   chk_win_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && match |=> window_match_flag)
      else $error("window match not flagged");

   chk_win_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      window_match_flag && !win_clr |=> window_match_flag)
      else $error("window flag dropped without clear");

   chk_inside_miss: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && !diff && !result_left_justify_r &&
      lt_word > gt_word && {6'h00, conv_data} >= lt_word &&
      !window_match_flag |=> !window_match_flag)
      else $error("flag set above less-than limit");

   chk_outside_hit: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && !diff && !result_left_justify_r &&
      lt_word < gt_word && {6'h00, conv_data} > gt_word
      |=> window_match_flag)
      else $error("flag missed above greater-than limit");

   chk_read_wait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   chk_write_nowait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      accept && hwrite |=> hreadyout)
      else $error("write data phase stalled");

   chk_single_word: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && !diff && !result_left_justify_r |=>
         {res_hi_r, res_lo_r} == {6'h00, $past(conv_data)})
      else $error("single-ended result not unsigned");

   chk_diff_word: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && diff && !result_left_justify_r |=>
         {res_hi_r, res_lo_r} ==
            {{6{$past(conv_data[9])}}, $past(conv_data)})
      else $error("differential result not two's complement");

   chk_temp_single: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && chan_sel_r[arfw_pkg::CHAN_TEMP_BIT] &&
      !result_left_justify_r |=> res_hi_r[7:2] == 6'h00)
      else $error("temperature result sign extended");

   chk_diff_signed: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done && diff && $signed(lt_word) > $signed(gt_word) &&
      $signed(fmt_word) < $signed(lt_word) &&
      $signed(fmt_word) > $signed(gt_word) |=> window_match_flag)
      else $error("signed window match missed");

   chk_win_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      win_clr && !(conv_done && match) |=> !window_match_flag)
      else $error("window flag not cleared by software");

   chk_win_quiet: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !window_match_flag && !(conv_done && match) |=> !window_match_flag)
      else $error("window flag set without a match");

   chk_result_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !conv_done && !wr_en |=> $stable(res_lo_r) && $stable(res_hi_r))
      else $error("result changed without a conversion");

   chk_done_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      conv_done |=> status_r[arfw_pkg::ST_DONE_BIT])
      else $error("conversion done not flagged");

   chk_irq_mask: assert property (
      @(posedge hclk) disable iff (!hresetn)
      window_match_flag && mask_r[arfw_pkg::ST_WIN_BIT] |-> irq)
      else $error("unmasked window flag without interrupt");
endmodule : arfw_top

`default_nettype wire

// ===== verif/arfw_top_tb.sv
// Purpose: self-checking bench for the result format and window block
// Assumes: one wait state on reads, none on writes, 8-bit registers on aligned words
// Notes: reads queue their expectation; a monitor compares at the answer
`timescale 1ns/1ps
`default_nettype none
module arfw_top_tb;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic conv_done, rd_pend;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [9:0] conv_data;
   logic [31:0] exp_q[$];
   int errors, n_compared;
   logic [7:0] ridx[8] = '{arfw_pkg::IDX_GT_HI, arfw_pkg::IDX_GT_LO,
      arfw_pkg::IDX_LT_HI, arfw_pkg::IDX_LT_LO, arfw_pkg::IDX_RES_HI,
      arfw_pkg::IDX_RES_LO, arfw_pkg::IDX_CTRL, arfw_pkg::IDX_STATUS};
   logic [7:0] rval[8] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
   // pair 0 single-ended, pair 1 differential, temperature channel
   logic [7:0] csel[3] = '{8'h00, 8'h02, 8'h08};
   assign hready = hreadyout;
   arfw_top u_arfw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .conv_done(conv_done),
      .conv_data(conv_data), .irq(irq));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      n_compared++;
      if (seen !== expv) begin
         errors++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, expv);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compared %0d, mismatched %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // ready is combinational, so the level at the falling edge is the level
   // seen at the next rising edge, with no race against the design's flops
   task automatic wait_rdy;
      logic r;
      r = 1'b0;
      for (int i = 0; i < 16 && !r; i++) begin
         @(negedge hclk);
         r = (hreadyout === 1'b1);
         @(posedge hclk);
      end
      if (!r) begin
         errors++;
         wrap_up();
      end
   endtask : wait_rdy
   task automatic bus(input logic [7:0] idx, input logic wr,
         input logic [7:0] wd, input logic [7:0] ed);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      if (!wr) begin
         exp_q.push_back({24'h0, ed});
         rd_pend = 1'b1;
      end
      wait_rdy();
      rd_pend = 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d, 8'h00);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(idx, 1'b0, 8'h00, e);
   endtask : rd
   task automatic conv(input logic [9:0] d);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge hclk);
      conv_done <= 1'b0;
      conv_data <= ~d;
   endtask : conv
   always @(negedge hclk) begin
      if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0) begin
         chk(hrdata, exp_q.pop_front());
         chk({31'h0, hresp}, {31'h0, arfw_pkg::HRESP_OKAY});
      end
   end
   function automatic logic [15:0] fmt(input logic [9:0] d,
         input logic lj, input logic df);
      if (lj) return {d, 6'h0};
      return df ? {{6{d[9]}}, d} : {6'h0, d};
   endfunction : fmt
   function automatic logic hit(input logic [15:0] r, lt, gt,
         input logic df);
      logic a, b, c;
      a = df ? ($signed(r) < $signed(lt)) : (r < lt);
      b = df ? ($signed(r) > $signed(gt)) : (r > gt);
      c = df ? ($signed(lt) > $signed(gt)) : (lt > gt);
      return c ? (a && b) : (a || b);
   endfunction : hit
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   initial begin
      logic [15:0] lt, gt, r;
      logic [9:0] dv[6];
      logic win, lj, df;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      conv_done = 1'b0;
      conv_data = 10'h0;
      rd_pend = 1'b0;
      errors = 0;
      n_compared = 0;
      seed = 32'h0000755B;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ridx[i]) rd(ridx[i], rval[i]);
      // unmapped index: write ignored, reads zero
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      win = 1'b0;
      for (int m = 0; m < 4; m++) begin
         lj = m[0];
         df = m[1];
         wr(arfw_pkg::IDX_CTRL, {7'h0, lj});
         wr(arfw_pkg::IDX_PAIR_CFG, {7'h0, df});
         wr(arfw_pkg::IDX_MASK, {6'h0, m[1:0]});
         for (int k = 0; k < 2; k++) begin
            // both limits are hit exactly, testing the strict comparisons
            dv = '{10'h080, 10'h3C0, seed[9:0], seed[19:10], 10'h3FF,
               10'h200};
            lt = fmt(k ? dv[0] : dv[1], lj, df);
            gt = fmt(k ? dv[1] : dv[0], lj, df);
            wr(arfw_pkg::IDX_LT_HI, lt[15:8]);
            wr(arfw_pkg::IDX_LT_LO, lt[7:0]);
            wr(arfw_pkg::IDX_GT_HI, gt[15:8]);
            wr(arfw_pkg::IDX_GT_LO, gt[7:0]);
            for (int i = 0; i < 6; i++) begin
               conv(dv[i]);
               r = fmt(dv[i], lj, df);
               win = win | hit(r, lt, gt, df);
               rd(arfw_pkg::IDX_RES_HI, r[15:8]);
               rd(arfw_pkg::IDX_RES_LO, r[7:0]);
               rd(arfw_pkg::IDX_STATUS, {6'h0, 1'b1, win});
               @(negedge hclk);
               chk({31'h0, irq}, {31'h0, (m[1:0] & {1'b1, win}) != 0});
               @(posedge hclk);
               seed = xs(seed);
            end
            rd(arfw_pkg::IDX_CTRL, {6'h0, win, lj});
            if (k) wr(arfw_pkg::IDX_CTRL, {6'h0, 1'b1, lj});
            else wr(arfw_pkg::IDX_STATUS, 8'h01);
            win = 1'b0;
            rd(arfw_pkg::IDX_STATUS, 8'h02);
         end
         wr(arfw_pkg::IDX_STATUS, 8'h03);
      end
      // pair selection and the always single-ended temperature channel
      wr(arfw_pkg::IDX_CTRL, 8'h00);
      wr(arfw_pkg::IDX_PAIR_CFG, 8'h0E);
      rd(arfw_pkg::IDX_PAIR_CFG, 8'h0E);
      rd(arfw_pkg::IDX_MASK, 8'h03);
      foreach (csel[c]) begin
         wr(arfw_pkg::IDX_CHAN_SEL, csel[c]);
         rd(arfw_pkg::IDX_CHAN_SEL, csel[c]);
         conv(10'h3FF);
         r = fmt(10'h3FF, 1'b0, c == 1);
         rd(arfw_pkg::IDX_RES_HI, r[15:8]);
      end
      wrap_up();
   end
endmodule : arfw_top_tb
`default_nettype wire
